// ===== inc/adcw_pkg.sv
// Constants and types shared by the converter result and window control block
package adcw_pkg;
  localparam int AXI_ADDR_W = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_MAIN = 5'h00;
  localparam logic [4:0] IDX_ACC = 5'h01;
  localparam logic [4:0] IDX_REF = 5'h02;
  localparam logic [4:0] IDX_DLY = 5'h03;
  localparam logic [4:0] IDX_WIN = 5'h04;
  localparam logic [4:0] IDX_SAMP = 5'h05;
  localparam logic [4:0] IDX_CHAN = 5'h06;
  localparam logic [4:0] IDX_CMD = 5'h08;
  localparam logic [4:0] IDX_EVT = 5'h09;
  localparam logic [4:0] IDX_IEN = 5'h0A;
  localparam logic [4:0] IDX_IFL = 5'h0B;
  localparam logic [4:0] IDX_DBG = 5'h0C;
  localparam logic [4:0] IDX_SCR = 5'h0D;
  localparam logic [4:0] IDX_OUT = 5'h10;
  localparam logic [4:0] IDX_WLT = 5'h12;
  localparam logic [4:0] IDX_WHT = 5'h14;
  localparam logic [4:0] IDX_CAL = 5'h16;
  localparam logic [4:0] IDX_STAT = 5'h18;
  // Writable bit masks
  localparam logic [7:0] MSK_MAIN = 8'h87;
  localparam logic [7:0] MSK_ACC = 8'h07;
  localparam logic [7:0] MSK_REF = 8'h77;
  localparam logic [7:0] MSK_DLY = 8'hFF;
  localparam logic [7:0] MSK_WIN = 8'h07;
  localparam logic [7:0] MSK_SAMP = 8'h1F;
  localparam logic [7:0] MSK_BIT0 = 8'h01;
  localparam logic [7:0] MSK_IRQ = 8'h03;
  // Field positions
  localparam int MAIN_EN = 0;
  localparam int MAIN_CONT = 1;
  localparam int MAIN_DEPTH = 2;
  localparam int MAIN_KEEP = 7;
  localparam int REF_LSB = 4;
  localparam int REF_CAP = 6;
  localparam int FLG_RDY = 0;
  localparam int FLG_WIN = 1;
  localparam logic [4:0] CHAN_TEMP = 5'h1E;
  localparam logic [2:0] ACC_RSVD = 3'h7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  typedef enum logic [2:0] {
    WM_NONE = 3'h0, WM_BELOW = 3'h1, WM_ABOVE = 3'h2, WM_INSIDE = 3'h3, WM_OUTSIDE = 3'h4
  } adcw_wmode_t;
  // Control toward the analog sampling front end
  typedef struct packed {
    logic start;
    logic halt;
    logic temp_en;
    logic sample_capacitance_select;
    logic [1:0] ref_sel;
    logic [4:0] chan;
  } adcw_afe_ctl_t;
  // Answer from the analog sampling front end
  typedef struct packed {
    logic done;
    logic [9:0] code;
  } adcw_afe_res_t;
endpackage : adcw_pkg

// ===== rtl/adcw_accum.sv
// Sample truncation and accumulation over one conversion
`timescale 1ns/1ps
module adcw_accum
  import adcw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clear_i,
  input wire logic sample_i,
  input wire logic [9:0] code_i,
  input wire logic depth8_i,
  input wire logic [2:0] acc_sel_i,
  output logic [15:0] sum_o,
  output logic last_o
);
  logic [15:0] sum_q;
  logic [6:0] cnt_q;
  logic [9:0] code_t;
  logic [6:0] need;

  // Upper eight bits only in reduced depth
  assign code_t = depth8_i ? {2'h0, code_i[9:2]} : code_i;
  // Reserved count code behaves as no accumulation
  assign need = (acc_sel_i == ACC_RSVD) ? 7'h01 : 7'(7'h01 << acc_sel_i);
  assign sum_o = sum_q + {6'h00, code_t};
  assign last_o = sample_i && ((cnt_q + 7'h01) == need);

  // Running total restarts with every conversion
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sum_q <= RST_WORD;
      cnt_q <= 7'h00;
    end else if (clear_i || last_o) begin
      sum_q <= RST_WORD;
      cnt_q <= 7'h00;
    end else if (sample_i) begin
      sum_q <= sum_o;
      cnt_q <= cnt_q + 7'h01;
    end
  end
endmodule : adcw_accum

// ===== rtl/adcw_window.sv
// Window comparator on the accumulated result
`timescale 1ns/1ps
module adcw_window
  import adcw_pkg::*;
(
  input wire logic [2:0] mode_i,
  input wire logic [15:0] res_i,
  input wire logic [15:0] lo_i,
  input wire logic [15:0] hi_i,
  output logic hit_o
);
  logic below;
  logic above;

  // Unsigned compares only
  assign below = res_i < lo_i;
  assign above = res_i > hi_i;

  // Mode zero and reserved codes never match
  always_comb begin
    unique case (mode_i)
      WM_NONE: hit_o = 1'b0;
      WM_BELOW: hit_o = below;
      WM_ABOVE: hit_o = above;
      WM_INSIDE: hit_o = (res_i > lo_i) && (res_i < hi_i);
      WM_OUTSIDE: hit_o = below || above;
      default: hit_o = 1'b0;
    endcase
  end
endmodule : adcw_window

// ===== rtl/adcw_top.sv
// Converter control top: register slave, conversion sequencing, flags and events
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adcw_top
  import adcw_pkg::*;
#(
  parameter int ADDR_W = AXI_ADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic event_i,
  input wire logic standby_i,
  input wire logic powerdown_i,
  input wire logic dbg_halt_i,
  input wire logic touch_en_i,
  input wire logic touch_start_i,
  input wire logic [4:0] touch_chan_i,
  input wire adcw_afe_res_t afe_res_i,
  output adcw_afe_ctl_t afe_ctl_o,
  output logic result_evt_o,
  output logic irq_o,
  output logic clk_req_o
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_BUSY = 2'b01} adcw_state_t;

  // Bus handshake state
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic arready_q;
  logic rvalid_q;
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] rdata_q;
  // Registers
  logic [7:0] main_q;
  logic [7:0] acc_q;
  logic [7:0] ref_q;
  logic [7:0] dly_q;
  logic [7:0] win_q;
  logic [7:0] samp_q;
  logic [7:0] chan_q;
  logic [7:0] evt_q;
  logic [7:0] ien_q;
  logic [7:0] dbg_q;
  logic [7:0] scr_q;
  logic [7:0] cal_q;
  logic [15:0] wlt_q;
  logic [15:0] wht_q;
  logic [15:0] result_q;
  // Sequencing state
  adcw_state_t state_q;
  logic start_bit_q;
  logic evt_prev_q;
  logic pd_seen_q;
  logic invalid_q;
  logic rdy_flag_q;
  logic win_flag_q;
  logic rdy_flag_d;
  logic win_flag_d;
  adcw_afe_ctl_t afe_ctl_q;
  logic result_evt_q;
  logic irq_q;
  logic clk_req_q;
  // Derived terms
  logic exec;
  logic [4:0] wr_idx;
  logic [4:0] rd_idx;
  logic ar_hs;
  logic active;
  logic halted;
  logic start_sw;
  logic start_ev;
  logic start_req;
  logic busy;
  logic sample_ok;
  logic last;
  logic conv_done;
  logic again;
  logic [15:0] acc_sum;
  logic win_hit;
  logic rd_out;
  logic clr_rdy;
  logic clr_win;

  // Byte-lane merge of a masked byte
  function automatic logic [7:0] wr8(input logic [7:0] old, input logic [7:0] dat,
                                     input logic en, input logic [7:0] msk);
    wr8 = en ? (dat & msk) : old;
  endfunction : wr8

  // Byte-lane merge of a 16-bit register in the low half word
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] dat,
                                       input logic [3:0] strb);
    wr16 = {strb[1] ? dat[15:8] : old[15:8], strb[0] ? dat[7:0] : old[7:0]};
  endfunction : wr16

  assign exec = aw_have_q && w_have_q && !bvalid_q;
  assign wr_idx = awaddr_q[6:2];
  assign rd_idx = s_axi_araddr_i[6:2];
  assign ar_hs = s_axi_arvalid_i && arready_q;
  assign busy = state_q == ST_BUSY;

  // Touch controller owns the converter while enabled
  assign active = main_q[MAIN_EN] && !touch_en_i;
  // Frozen in power-down, plain standby, or debug break without run
  assign halted = powerdown_i || (standby_i && !main_q[MAIN_KEEP]) || (dbg_halt_i && !dbg_q[0]);
  assign start_sw = exec && (wr_idx == IDX_CMD) && wstrb_q[0] && wdata_q[0];
  // Edge-sensitive event trigger, ignored while frozen
  assign start_ev = event_i && !evt_prev_q && evt_q[0] && !halted;
  assign start_req = active && !busy && (start_sw || start_ev);
  // Front-end answers are taken only when not frozen
  assign sample_ok = active && busy && afe_res_i.done && !halted;
  assign conv_done = sample_ok && last;
  assign again = sample_ok && (!last || main_q[MAIN_CONT]);

  adcw_accum u_accum (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(start_req),
    .sample_i(sample_ok),
    .code_i(afe_res_i.code),
    .depth8_i(main_q[MAIN_DEPTH]),
    .acc_sel_i(acc_q[2:0]),
    .sum_o(acc_sum),
    .last_o(last)
  );

  adcw_window u_window (
    .mode_i(win_q[2:0]),
    .res_i(acc_sum),
    .lo_i(wlt_q),
    .hi_i(wht_q),
    .hit_o(win_hit)
  );

  // Write address and data are taken independently, one write at a time
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && awready_q) begin
        awaddr_q <= s_axi_awaddr_i;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end else if (exec) begin
        aw_have_q <= 1'b0;
      end else if (!aw_have_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (s_axi_wvalid_i && wready_q) begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end else if (exec) begin
        w_have_q <= 1'b0;
      end else if (!w_have_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (exec) begin
        bvalid_q <= 1'b1;
      end else if (s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read data is captured at the address handshake and held until taken
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      unique case (rd_idx)
        IDX_MAIN: rdata_q <= {24'h0, main_q};
        IDX_ACC: rdata_q <= {24'h0, acc_q};
        IDX_REF: rdata_q <= {24'h0, ref_q};
        IDX_DLY: rdata_q <= {24'h0, dly_q};
        IDX_WIN: rdata_q <= {24'h0, win_q};
        IDX_SAMP: rdata_q <= {24'h0, samp_q};
        IDX_CHAN: rdata_q <= {24'h0, chan_q};
        IDX_CMD: rdata_q <= {31'h0, start_bit_q};
        IDX_EVT: rdata_q <= {24'h0, evt_q};
        IDX_IEN: rdata_q <= {24'h0, ien_q};
        IDX_IFL: rdata_q <= {30'h0, win_flag_q, rdy_flag_q};
        IDX_DBG: rdata_q <= {24'h0, dbg_q};
        IDX_SCR: rdata_q <= {24'h0, scr_q};
        IDX_OUT: rdata_q <= {16'h0, result_q};
        IDX_WLT: rdata_q <= {16'h0, wlt_q};
        IDX_WHT: rdata_q <= {16'h0, wht_q};
        IDX_CAL: rdata_q <= {24'h0, cal_q};
        IDX_STAT: rdata_q <= {30'h0, busy, invalid_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (rvalid_q) begin
      if (s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end else begin
      arready_q <= 1'b1;
    end
  end

  // Configuration registers; reserved bits are masked away on write
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_q <= RST_BYTE;
      acc_q <= RST_BYTE;
      ref_q <= RST_BYTE;
      dly_q <= RST_BYTE;
      win_q <= RST_BYTE;
      samp_q <= RST_BYTE;
      chan_q <= RST_BYTE;
      evt_q <= RST_BYTE;
      ien_q <= RST_BYTE;
      dbg_q <= RST_BYTE;
      scr_q <= RST_BYTE;
      cal_q <= RST_BYTE;
      wlt_q <= RST_WORD;
      wht_q <= RST_WORD;
    end else if (exec) begin
      unique case (wr_idx)
        IDX_MAIN: main_q <= wr8(main_q, wdata_q[7:0], wstrb_q[0], MSK_MAIN);
        IDX_ACC: acc_q <= wr8(acc_q, wdata_q[7:0], wstrb_q[0], MSK_ACC);
        IDX_REF: ref_q <= wr8(ref_q, wdata_q[7:0], wstrb_q[0], MSK_REF);
        IDX_DLY: dly_q <= wr8(dly_q, wdata_q[7:0], wstrb_q[0], MSK_DLY);
        IDX_WIN: win_q <= wr8(win_q, wdata_q[7:0], wstrb_q[0], MSK_WIN);
        IDX_SAMP: samp_q <= wr8(samp_q, wdata_q[7:0], wstrb_q[0], MSK_SAMP);
        IDX_CHAN: chan_q <= wr8(chan_q, wdata_q[7:0], wstrb_q[0], MSK_SAMP);
        IDX_EVT: evt_q <= wr8(evt_q, wdata_q[7:0], wstrb_q[0], MSK_BIT0);
        IDX_IEN: ien_q <= wr8(ien_q, wdata_q[7:0], wstrb_q[0], MSK_IRQ);
        IDX_DBG: dbg_q <= wr8(dbg_q, wdata_q[7:0], wstrb_q[0], MSK_BIT0);
        IDX_SCR: scr_q <= wr8(scr_q, wdata_q[7:0], wstrb_q[0], MSK_DLY);
        IDX_CAL: cal_q <= wr8(cal_q, wdata_q[7:0], wstrb_q[0], MSK_BIT0);
        IDX_WLT: wlt_q <= wr16(wlt_q, wdata_q, wstrb_q);
        IDX_WHT: wht_q <= wr16(wht_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // Conversion sequencer: idle until started, busy until the last sample, or in continuous mode until disabled
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
    end else if (!active) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start_req) state_q <= ST_BUSY;
        ST_BUSY: if (conv_done && !main_q[MAIN_CONT]) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Start bit reads one for as long as a conversion is under way
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_bit_q <= 1'b0;
    end else if (!active) begin
      start_bit_q <= 1'b0;
    end else if (start_req) begin
      start_bit_q <= 1'b1;
    end else if (conv_done && !main_q[MAIN_CONT]) begin
      start_bit_q <= 1'b0;
    end
  end

  // Event edge memory, result store and power-down validity tracking
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evt_prev_q <= 1'b0;
      pd_seen_q <= 1'b0;
      invalid_q <= 1'b0;
      result_q <= RST_WORD;
    end else begin
      evt_prev_q <= event_i;
      if (start_req) begin
        pd_seen_q <= 1'b0;
      end else if (busy && powerdown_i) begin
        pd_seen_q <= 1'b1;
      end
      if (conv_done) begin
        result_q <= acc_sum;
        invalid_q <= pd_seen_q;
      end
    end
  end

  // Flags clear on write-one or result read; a completion in that cycle wins
  assign rd_out = ar_hs && (rd_idx == IDX_OUT);
  assign clr_rdy = rd_out || (exec && wr_idx == IDX_IFL && wstrb_q[0] && wdata_q[FLG_RDY]);
  assign clr_win = rd_out || (exec && wr_idx == IDX_IFL && wstrb_q[0] && wdata_q[FLG_WIN]);
  assign rdy_flag_d = conv_done ? 1'b1 : (clr_rdy ? 1'b0 : rdy_flag_q);
  assign win_flag_d = (conv_done && win_hit) ? 1'b1 : (clr_win ? 1'b0 : win_flag_q);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdy_flag_q <= 1'b0;
      win_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rdy_flag_q <= rdy_flag_d;
      win_flag_q <= win_flag_d;
      irq_q <= |({win_flag_d, rdy_flag_d} & ien_q[1:0]);
    end
  end

  // Front-end control; channel and reference lock while a conversion runs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      afe_ctl_q <= '0;
    end else if (touch_en_i) begin
      afe_ctl_q.start <= touch_start_i;
      afe_ctl_q.halt <= powerdown_i;
      afe_ctl_q.chan <= touch_chan_i;
      afe_ctl_q.temp_en <= 1'b0;
    end else begin
      afe_ctl_q.start <= start_req || again;
      afe_ctl_q.halt <= halted;
      if (!busy) begin
        afe_ctl_q.chan <= chan_q[4:0];
        afe_ctl_q.ref_sel <= ref_q[REF_LSB+1:REF_LSB];
        afe_ctl_q.sample_capacitance_select <= ref_q[REF_CAP];
      end
      afe_ctl_q.temp_en <= chan_q[4:0] == CHAN_TEMP;
    end
  end

  // Result event and standby clock request
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_evt_q <= 1'b0;
      clk_req_q <= 1'b0;
    end else begin
      result_evt_q <= conv_done && main_q[MAIN_EN];
      clk_req_q <= standby_i && (start_req || (busy && !conv_done) || again);
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = RESP_OKAY;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = RESP_OKAY;
  assign afe_ctl_o = afe_ctl_q;
  assign result_evt_o = result_evt_q;
  assign irq_o = irq_q;
  assign clk_req_o = clk_req_q;
endmodule : adcw_top

// ===== dv/adcw_sva.sv
// Port checker for the converter control top
`timescale 1ns/1ps
module adcw_chk
  import adcw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire adcw_afe_res_t afe_res_i,
  input wire adcw_afe_ctl_t afe_ctl_o,
  input wire logic result_evt_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Bus steps
  sequence s_b_taken; s_axi_bvalid_o && s_axi_bready_i; endsequence
  sequence s_ar_taken; s_axi_arvalid_i && s_axi_arready_o; endsequence
  sequence s_r_wait; s_axi_rvalid_o && !s_axi_rready_i; endsequence
  // No bus access open, so no flag clear can be in flight
  logic quiet;
  assign quiet = s_axi_awready_o && s_axi_arready_o && !s_axi_awvalid_i && !s_axi_arvalid_i;
  chk_evt_one_cycle: assert property (result_evt_o |=> !result_evt_o)
    else $error("result event longer than one cycle");
  chk_evt_after_done: assert property (result_evt_o |-> $past(afe_res_i.done))
    else $error("result event without a sample completion");
  chk_irq_holds: assert property (irq_o && quiet |=> irq_o)
    else $error("interrupt dropped without a flag clear");
  chk_start_pulse: assert property (afe_ctl_o.start |=> !afe_ctl_o.start)
    else $error("start pulse longer than one cycle");
  chk_b_okay: assert property (s_axi_bvalid_o |-> s_axi_bresp_o == RESP_OKAY)
    else $error("write response not okay");
  chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response withdrawn");
  chk_aw_reopen: assert property (s_b_taken |=> !s_axi_awready_o)
    else $error("write address reopened too early");
  chk_r_latency: assert property (s_ar_taken |=> s_axi_rvalid_o)
    else $error("read data late");
  chk_r_stable: assert property (s_r_wait |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data changed while waiting");
endmodule : adcw_chk

// ===== dv/adcw_afe_model.sv
// Behavioural analog front end answering each start with one sample
`timescale 1ns/1ps
module adcw_afe_model
  import adcw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire adcw_afe_ctl_t ctl_i,
  input wire logic [3:0] lat_i,
  input wire logic [9:0] code_i,
  output adcw_afe_res_t res_o
);
  logic busy_q;
  logic [3:0] cnt_q;
  // Code lines toggle outside a sample so a stale code never looks valid
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'h0;
      cnt_q <= 4'h0;
      res_o <= 11'h000;
    end else if (ctl_i.start) begin
      busy_q <= 1'h1;
      cnt_q <= lat_i;
      res_o <= {1'h0, ~res_o.code};
    end else if (busy_q && !ctl_i.halt && cnt_q == 4'h0) begin
      busy_q <= 1'h0;
      res_o <= {1'h1, code_i};
    end else begin
      cnt_q <= cnt_q - {3'h0, busy_q && !ctl_i.halt};
      res_o <= {1'h0, ~res_o.code};
    end
  end
endmodule : adcw_afe_model

// ===== dv/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
  import adcw_pkg::*;
  logic clk_i, rst_b_i, event_i, standby_i, powerdown_i, touch_en_i, touch_start_i, result_evt_o, irq_o, clk_req_o;
  logic [6:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [4:0] touch_chan_i;
  logic [3:0] lat;
  logic [9:0] code;
  adcw_afe_res_t afe_res_i;
  adcw_afe_ctl_t afe_ctl_o;
  int error_cnt = 0;
  int checks_done = 0;
  logic [4:0] ridx [7] = '{IDX_MAIN, IDX_ACC, IDX_REF, IDX_DLY, IDX_WIN, IDX_SAMP, 5'h07};
  logic [7:0] rmsk [7] = '{MSK_MAIN, MSK_ACC, MSK_REF, MSK_DLY, MSK_WIN, MSK_SAMP, 8'h00};
  adcw_top DUT (.clk_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awprot_i(3'h0), .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arprot_i(3'h0), .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .event_i, .standby_i, .powerdown_i, .dbg_halt_i(1'h0),
    .touch_en_i, .touch_start_i, .touch_chan_i, .afe_res_i, .afe_ctl_o, .result_evt_o, .irq_o, .clk_req_o);
  adcw_afe_model u_afe (.clk_i, .rst_b_i, .ctl_i(afe_ctl_o), .lat_i(lat), .code_i(code), .res_o(afe_res_i));
  // Clock at 20 MHz
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // Bus master: address and data offered together, each released when taken
  task automatic axi_wr(input logic [4:0] idx, input logic [31:0] d);
    logic a;
    logic w;
    a = 1'h0;
    w = 1'h0;
    s_axi_awaddr_i <= {idx, 2'h0};
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    while (!(a && w)) begin
      @(posedge clk_i);
      if (!a && s_axi_awready_o) begin a = 1'h1; s_axi_awvalid_i <= 1'h0; end
      if (!w && s_axi_wready_o) begin w = 1'h1; s_axi_wvalid_i <= 1'h0; end
    end
    do @(posedge clk_i); while (s_axi_bvalid_o !== 1'h1);
    s_axi_bready_i <= 1'h0;
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] idx, output logic [31:0] d);
    s_axi_araddr_i <= {idx, 2'h0};
    s_axi_arvalid_i <= 1'h1;
    do @(posedge clk_i); while (s_axi_arready_o !== 1'h1);
    s_axi_arvalid_i <= 1'h0;
    s_axi_rready_i <= 1'h1;
    do @(posedge clk_i); while (s_axi_rvalid_o !== 1'h1);
    d = s_axi_rdata_o;
    s_axi_rready_i <= 1'h0;
  endtask : axi_rd
  task automatic rc(input logic [4:0] idx, input logic [31:0] e);
    logic [31:0] d;
    axi_rd(idx, d);
    check(d, e);
    check(s_axi_rresp_o, 32'(RESP_OKAY));
  endtask : rc
  task automatic wait_evt(input int lim, output logic got);
    got = 1'h0;
    repeat (lim) begin
      @(posedge clk_i);
      if (result_evt_o === 1'h1) begin got = 1'h1; break; end
    end
  endtask : wait_evt
  task automatic ev_pulse();
    event_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    event_i <= 1'h0;
    @(posedge clk_i);
  endtask : ev_pulse
  function automatic logic [15:0] exp_res(logic [9:0] c, logic d8, logic [2:0] acc);
    return (d8 ? {8'h00, c[9:2]} : {6'h00, c}) << acc;
  endfunction : exp_res
  function automatic logic win_exp(logic [2:0] m, logic [15:0] r, logic [15:0] lo, logic [15:0] hi);
    case (m)
      3'h1: return r < lo;
      3'h2: return r > hi;
      3'h3: return (r > lo) && (r < hi);
      3'h4: return (r < lo) || (r > hi);
      default: return 1'h0;
    endcase
  endfunction : win_exp
  // Thresholds first, then mode, then one conversion checked end to end
  task automatic conv(input logic [2:0] m, input logic [15:0] lo, hi, r, input logic d8, input logic [2:0] acc);
    logic g;
    axi_wr(IDX_WLT, {16'h0000, lo});
    axi_wr(IDX_WHT, {16'h0000, hi});
    axi_wr(IDX_IEN, 32'h3);
    axi_wr(IDX_WIN, {29'h0, m});
    axi_wr(IDX_ACC, {29'h0, acc});
    axi_wr(IDX_MAIN, {29'h0, d8, 2'h1});
    axi_wr(IDX_CMD, 32'h1);
    rc(IDX_CMD, 32'h1);
    wait_evt(400, g);
    check(g, 32'h1);
    check(irq_o, 32'h1);
    rc(IDX_IFL, {30'h0, win_exp(m, r, lo, hi), 1'h1});
    rc(IDX_OUT, {16'h0000, r});
    rc(IDX_IFL, 32'h0);
    check(irq_o, 32'h0);
    rc(IDX_CMD, 32'h0);
  endtask : conv
  initial begin
    logic [31:0] v;
    logic [15:0] r;
    logic g;
    logic d8;
    logic [2:0] acc;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h00;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 46'h0;
    {event_i, standby_i, powerdown_i, touch_en_i, touch_start_i, touch_chan_i, lat, code} = 24'h0;
    rst_b_i = 1'h0;
    v = $urandom(85378);
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 7; i++) begin
      rc(ridx[i], 32'h0);
      axi_wr(ridx[i], 32'hFFFFFFFF);
      rc(ridx[i], {24'h0, rmsk[i]});
      axi_wr(ridx[i], 32'h0);
    end
    // Random codes; later passes put both thresholds on the result
    for (int i = 0; i < 10; i++) begin
      d8 = 1'($urandom);
      acc = 3'($urandom % 3);
      code <= 10'($urandom);
      lat <= 4'(8 + $urandom % 8);
      @(posedge clk_i);
      r = exp_res(code, d8, acc);
      v = (i < 5) ? $urandom % 4096 : r;
      conv(3'(i % 5), v[15:0], (i < 5) ? 16'($urandom) : r, r, d8, acc);
    end
    axi_wr(IDX_WIN, 32'h0);
    axi_wr(IDX_EVT, 32'h1);
    ev_pulse();
    wait_evt(200, g);
    check(g, 32'h1);
    axi_wr(IDX_EVT, 32'h0);
    ev_pulse();
    wait_evt(60, g);
    check(g, 32'h0);
    axi_wr(IDX_EVT, 32'h1);
    axi_wr(IDX_MAIN, 32'h81);
    axi_wr(IDX_DLY, 32'h20);
    standby_i <= 1'h1;
    ev_pulse();
    check(clk_req_o, 32'h1);
    wait_evt(200, g);
    check(g, 32'h1);
    repeat (3) @(posedge clk_i);
    check(clk_req_o, 32'h0);
    axi_wr(IDX_MAIN, 32'h1);
    ev_pulse();
    wait_evt(60, g);
    check(g, 32'h0);
    standby_i <= 1'h0;
    axi_rd(IDX_OUT, v);
    axi_wr(IDX_CMD, 32'h1);
    powerdown_i <= 1'h1;
    wait_evt(40, g);
    check(g, 32'h0);
    check(afe_ctl_o.halt, 32'h1);
    powerdown_i <= 1'h0;
    wait_evt(200, g);
    check(g, 32'h1);
    rc(IDX_STAT, 32'h1);
    axi_wr(IDX_IFL, 32'h0);
    rc(IDX_IFL, 32'h1);
    axi_wr(IDX_IFL, 32'h3);
    rc(IDX_IFL, 32'h0);
    axi_wr(IDX_REF, 32'h40);
    axi_wr(IDX_CHAN, {27'h0, CHAN_TEMP});
    @(posedge clk_i);
    check(afe_ctl_o.temp_en, 32'h1);
    check(afe_ctl_o.sample_capacitance_select, 32'h1);
    touch_chan_i <= 5'($urandom);
    touch_en_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    check(afe_ctl_o.chan, touch_chan_i);
    touch_start_i <= 1'h1;
    @(posedge clk_i);
    touch_start_i <= 1'h0;
    @(posedge clk_i);
    check(afe_ctl_o.start, 32'h1);
    axi_wr(IDX_CMD, 32'h1);
    wait_evt(60, g);
    check(g, 32'h0);
    touch_en_i <= 1'h0;
    axi_wr(IDX_MAIN, 32'h3);
    axi_wr(IDX_CMD, 32'h1);
    repeat (3) begin
      wait_evt(100, g);
      check(g, 32'h1);
    end
    axi_wr(IDX_MAIN, 32'h1);
    repeat (100) @(posedge clk_i);
    rc(IDX_CMD, 32'h0);
    end_sim();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    end_sim();
  end
endmodule : testbench
bind adcw_top adcw_chk u_chk (.clk_i, .rst_b_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_bresp_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .afe_res_i, .afe_ctl_o, .result_evt_o, .irq_o);
